/* File: rtl/gpio_function_select.sv */
`timescale 1ns/1ps
module gpio_function_select
#(
  parameter int slip_cycles = gpio_pkg::slip_process_cycles
)
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       ce,
  // Register access from the serial-port logic
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  // Shared pin
  input  wire logic       general_purpose_input,
  output logic            status_output_pin_out,
  output logic            status_output_pin_oe_n,
  // Internal status sources
  input  wire logic       alarm,
  input  wire logic       serial_readback_line,
  input  wire logic       sysref_unsynced,
  input  wire logic       phase_status,
  input  wire logic       sync_request_status,
  input  wire logic       channel_fsm_busy,
  input  wire logic [3:0] sysref_fsm_state,
  input  wire logic       pulse_request_status,
  // Device actions
  output logic            sleep_mode,
  output logic            output_network_disable,
  output logic            io_buffer_disable,
  output logic            mute_drivers,
  output logic            pulse_generator_request,
  output logic            reseed_request,
  output logic            restart_request,
  output logic            slip_request,
  output logic            phase_sync_alarm_set
);

  localparam int count_width = $clog2(slip_cycles + 1);

  // Elaboration-time guard: the slip counter needs at least one cycle
  if (slip_cycles < 1)
  begin : slip_cycles_check
    $error("slip_cycles must be at least one");
  end

  logic [gpio_pkg::input_ctrl_width-1:0]  input_ctrl;
  logic [gpio_pkg::output_ctrl_width-1:0] output_ctrl;
  logic                                   pin_meta;
  logic                                   pin_sync;
  logic                                   pin_prev;
  logic [3:0]                             input_code;
  logic                                   input_enabled;
  logic                                   pin_rise;
  logic                                   next_sleep;
  logic                                   next_mute;
  logic                                   next_pulse;
  logic                                   next_reseed;
  logic                                   next_restart;
  logic                                   next_slip;
  logic [count_width-1:0]                 slip_count;
  logic                                   slip_pending;

  // Configuration writes; restart never touches these
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      input_ctrl  <= gpio_pkg::input_ctrl_reset;
      output_ctrl <= gpio_pkg::output_ctrl_reset;
    end
    else if (ce && reg_write)
    begin
      if (reg_addr == gpio_pkg::input_ctrl_addr)
        input_ctrl <= reg_wdata[gpio_pkg::input_ctrl_width-1:0];
      if (reg_addr == gpio_pkg::output_ctrl_addr)
        output_ctrl <= reg_wdata[gpio_pkg::output_ctrl_width-1:0];
    end
  end

  // Readback; unused and reserved bits read zero
  always_ff @(posedge clk)
  begin
    if (reset)
      reg_rdata <= 8'h00;
    else if (ce && reg_read)
    begin
      if (reg_addr == gpio_pkg::input_ctrl_addr)
        reg_rdata <= {3'h0, input_ctrl};
      else if (reg_addr == gpio_pkg::output_ctrl_addr)
        reg_rdata <= {1'h0, output_ctrl};
      else
        reg_rdata <= 8'h00;
    end
  end

  // Pin comes from the board, so it is synchronised first
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
    end
    else if (ce)
    begin
      pin_meta <= general_purpose_input;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign input_code    = {input_ctrl[gpio_pkg::input_code_ext],
                          input_ctrl[gpio_pkg::input_code_msb:
                                     gpio_pkg::input_code_lsb]};
  // Decoding waits on enable, so a code change made while disabled is
  // never seen half written
  assign input_enabled = input_ctrl[gpio_pkg::input_enable_bit];
  assign pin_rise      = pin_sync && !pin_prev;

  always_comb
  begin
    next_sleep   = 1'b0;
    next_mute    = 1'b0;
    next_pulse   = 1'b0;
    next_reseed  = 1'b0;
    next_restart = 1'b0;
    next_slip    = 1'b0;
    if (input_enabled)
    begin
      unique case (input_code)
        gpio_pkg::input_sleep:   next_sleep   = pin_sync;
        gpio_pkg::input_mute:    next_mute    = pin_sync;
        gpio_pkg::input_pulse:   next_pulse   = pin_sync;
        gpio_pkg::input_reseed:  next_reseed  = pin_rise;
        gpio_pkg::input_restart: next_restart = pin_rise;
        gpio_pkg::input_slip:    next_slip    = pin_rise;
        default:                 next_sleep   = 1'b0;
      endcase
    end
  end

  // Level actions follow the pin; one-shot actions fire on its rising edge
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sleep_mode              <= 1'b0;
      mute_drivers            <= 1'b0;
      pulse_generator_request <= 1'b0;
      reseed_request          <= 1'b0;
      restart_request         <= 1'b0;
      slip_request            <= 1'b0;
    end
    else if (ce)
    begin
      sleep_mode              <= next_sleep;
      mute_drivers            <= next_mute;
      pulse_generator_request <= next_pulse;
      reseed_request          <= next_reseed;
      restart_request         <= next_restart;
      slip_request            <= next_slip;
    end
  end

  // Sleep shuts the buffers; mute leaves them and the dividers alone
  assign output_network_disable = sleep_mode;
  assign io_buffer_disable      = sleep_mode;

  // Slip processing delay; a new slip during processing restarts it
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      slip_count           <= '0;
      slip_pending         <= 1'b0;
      phase_sync_alarm_set <= 1'b0;
    end
    else if (ce)
    begin
      phase_sync_alarm_set <= 1'b0;
      if (slip_request)
      begin
        slip_pending <= 1'b1;
        slip_count   <= count_width'(slip_cycles - 1);
      end
      else if (slip_pending)
      begin
        if (slip_count == '0)
        begin
          slip_pending         <= 1'b0;
          phase_sync_alarm_set <= 1'b1;
        end
        else
          slip_count <= slip_count - 1'b1;
      end
    end
  end

  pin_drive_if drive ();

  assign drive.output_function_code = output_ctrl[gpio_pkg::output_code_msb:
                                          gpio_pkg::output_code_lsb];
  assign drive.output_driver_type   = output_ctrl[gpio_pkg::output_type_bit];
  assign drive.output_driver_enable =
    output_ctrl[gpio_pkg::output_enable_bit];
  assign drive.sleep_active         = sleep_mode;
  assign drive.alarm                = alarm;
  assign drive.serial_readback_line = serial_readback_line;
  assign drive.sysref_unsynced      = sysref_unsynced;
  assign drive.phase_status         = phase_status;
  assign drive.sync_request_status  = sync_request_status;
  assign drive.channel_fsm_busy     = channel_fsm_busy;
  assign drive.sysref_fsm_state     = sysref_fsm_state;
  assign drive.pulse_request_status = pulse_request_status;

  // Output path runs independently of the input decode, except that sleep_mode releases the pin
  status_output_driver driver_inst
  (
    .clk                    (clk),
    .reset                  (reset),
    .ce                     (ce),
    .cfg                    (drive),
    .status_output_pin_out  (status_output_pin_out),
    .status_output_pin_oe_n (status_output_pin_oe_n)
  );

endmodule

/* File: rtl/gpio_pkg.sv */
package gpio_pkg;

  // Register addresses on the serial-port register map
  localparam logic [7:0] input_ctrl_addr  = 8'h46;
  localparam logic [7:0] output_ctrl_addr = 8'h50;

  // Reset contents: every function disabled
  localparam logic [4:0] input_ctrl_reset  = 5'h00;
  localparam logic [6:0] output_ctrl_reset = 7'h00;

  // Input control field layout
  localparam int input_enable_bit = 0;
  localparam int input_code_lsb   = 1;
  localparam int input_code_msb   = 3;
  // Extension bit that carries the high code bit of the slip function
  localparam int input_code_ext   = 4;
  localparam int input_ctrl_width = 5;

  // Output control field layout
  localparam int output_enable_bit = 0;
  localparam int output_type_bit   = 1;
  localparam int output_code_lsb   = 2;
  localparam int output_code_msb   = 6;
  localparam int output_ctrl_width = 7;

  typedef enum logic [3:0] {
    input_none    = 4'h0,
    input_sleep   = 4'h2,
    input_mute    = 4'h3,
    input_pulse   = 4'h4,
    input_reseed  = 4'h5,
    input_restart = 4'h6,
    input_slip    = 4'h8
  } input_function_t;

  localparam logic [4:0] out_alarm         = 5'h00;
  localparam logic [4:0] out_readback      = 5'h01;
  localparam logic [4:0] out_sysref_unsync = 5'h02;
  localparam logic [4:0] out_phase_status  = 5'h03;
  localparam logic [4:0] out_sync_request  = 5'h04;
  localparam logic [4:0] out_channel_busy  = 5'h05;
  localparam logic [4:0] out_fsm_state0    = 5'h06;
  localparam logic [4:0] out_fsm_state3    = 5'h09;
  localparam logic [4:0] out_force_one     = 5'h0A;
  localparam logic [4:0] out_force_zero    = 5'h0B;
  localparam logic [4:0] out_pulse_status  = 5'h19;

  localparam logic open_drain_type = 1'b0;
  localparam logic push_pull_type  = 1'b1;

  // Cycles the dividers take to process a slip before the alarm
  localparam int slip_process_cycles = 16;

endpackage

/* File: rtl/pin_drive_if.sv */
`timescale 1ns/1ps
interface pin_drive_if;
  logic [4:0] output_function_code;
  logic       output_driver_type;
  logic       output_driver_enable;
  logic       sleep_active;
  logic       alarm;
  logic       serial_readback_line;
  logic       sysref_unsynced;
  logic       phase_status;
  logic       sync_request_status;
  logic       channel_fsm_busy;
  logic [3:0] sysref_fsm_state;
  logic       pulse_request_status;

  modport source
  (
    output output_function_code,
    output output_driver_type,
    output output_driver_enable,
    output sleep_active,
    output alarm,
    output serial_readback_line,
    output sysref_unsynced,
    output phase_status,
    output sync_request_status,
    output channel_fsm_busy,
    output sysref_fsm_state,
    output pulse_request_status
  );

  modport driver
  (
    input output_function_code,
    input output_driver_type,
    input output_driver_enable,
    input sleep_active,
    input alarm,
    input serial_readback_line,
    input sysref_unsynced,
    input phase_status,
    input sync_request_status,
    input channel_fsm_busy,
    input sysref_fsm_state,
    input pulse_request_status
  );
endinterface

/* File: rtl/status_output_driver.sv */
`timescale 1ns/1ps
module status_output_driver
(
  input  wire logic     clk,
  input  wire logic     reset,
  input  wire logic     ce,
  pin_drive_if.driver   cfg,
  output logic          status_output_pin_out,
  output logic          status_output_pin_oe_n
);

  logic selected_level;

  always_comb
  begin
    selected_level = 1'b0;
    if (cfg.output_function_code >= gpio_pkg::out_fsm_state0 &&
        cfg.output_function_code <= gpio_pkg::out_fsm_state3)
    begin
      selected_level = cfg.sysref_fsm_state[2'(cfg.output_function_code
                       - gpio_pkg::out_fsm_state0)];
    end
    else
    begin
      unique case (cfg.output_function_code)
        gpio_pkg::out_alarm:         selected_level = cfg.alarm;
        gpio_pkg::out_readback:
          selected_level = cfg.serial_readback_line;
        gpio_pkg::out_sysref_unsync:
          selected_level = cfg.sysref_unsynced;
        gpio_pkg::out_phase_status:
          selected_level = cfg.phase_status;
        gpio_pkg::out_sync_request:
          selected_level = cfg.sync_request_status;
        gpio_pkg::out_channel_busy:
          selected_level = cfg.channel_fsm_busy;
        gpio_pkg::out_force_one:     selected_level = 1'b1;
        gpio_pkg::out_force_zero:    selected_level = 1'b0;
        gpio_pkg::out_pulse_status:
          selected_level = cfg.pulse_request_status;
        // Reserved codes hold the pin at a fixed low
        default:                     selected_level = 1'b0;
      endcase
    end
  end

  // Open drain releases the pin for a one and pulls it low for a zero
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      status_output_pin_out  <= 1'b0;
      status_output_pin_oe_n <= 1'b1;
    end
    else if (ce)
    begin
      if (!cfg.output_driver_enable || cfg.sleep_active)
      begin
        status_output_pin_out  <= 1'b0;
        status_output_pin_oe_n <= 1'b1;
      end
      else if (cfg.output_driver_type == gpio_pkg::push_pull_type)
      begin
        status_output_pin_out  <= selected_level;
        status_output_pin_oe_n <= 1'b0;
      end
      else
      begin
        status_output_pin_out  <= 1'b0;
        status_output_pin_oe_n <= selected_level;
      end
    end
  end

endmodule

/* File: test/gpio_function_select_props.sv */
`timescale 1ns/1ps
module gpio_function_select_props
#(
  parameter int slip_cycles = 2
)
(
  input wire logic       clk,
  input wire logic       reset,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       general_purpose_input,
  input wire logic       status_output_pin_out,
  input wire logic       status_output_pin_oe_n,
  input wire logic       sleep_mode,
  input wire logic       output_network_disable,
  input wire logic       io_buffer_disable,
  input wire logic       mute_drivers,
  input wire logic       pulse_generator_request,
  input wire logic       reseed_request,
  input wire logic       restart_request,
  input wire logic       slip_request,
  input wire logic       phase_sync_alarm_set
);
  localparam int alarm_delay = slip_cycles + 1;
  wire logic [5:0] actions = {sleep_mode, mute_drivers,
    pulse_generator_request, reseed_request, restart_request, slip_request};
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence alarm_due;
    ##alarm_delay phase_sync_alarm_set;
  endsequence
  net_copy_a:
    assert property (output_network_disable == sleep_mode
    && io_buffer_disable == sleep_mode) else $error("sleep copies differ");
  sleep_float_a:
    assert property (sleep_mode && $past(sleep_mode) |->
    status_output_pin_oe_n && !status_output_pin_out)
    else $error("pin driven in sleep");
  reseed_pulse_a:
    assert property (reseed_request |=> !reseed_request)
    else $error("reseed pulse too long");
  restart_pulse_a:
    assert property (restart_request |=> !restart_request)
    else $error("restart pulse too long");
  slip_alarm_a:
    assert property (slip_request |-> alarm_due)
    else $error("no alarm after slip");
  alarm_cause_a:
    assert property (phase_sync_alarm_set |->
    $past(slip_request, alarm_delay)) else $error("alarm without slip");
  one_action_a:
    assert property ($onehot0(actions))
    else $error("two actions at once");
  pulse_level_a:
    assert property ($rose(pulse_generator_request) |->
    $past(general_purpose_input)) else $error("pulse request without pin");
  unmapped_read_a:
    assert property (reg_read && reg_addr != 8'h46 &&
    reg_addr != 8'h50 |=> reg_rdata == 8'h00) else $error("unmapped read");
  spare_bits_a:
    assert property (reg_read && reg_addr == 8'h46 |=>
    reg_rdata[7:5] == 3'h0) else $error("spare input bits set");
endmodule

bind gpio_function_select gpio_function_select_props #(.slip_cycles(slip_cycles))
  gpio_function_select_props_inst (.clk(clk), .reset(reset),
  .reg_addr(reg_addr), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .general_purpose_input(general_purpose_input),
  .status_output_pin_out(status_output_pin_out),
  .status_output_pin_oe_n(status_output_pin_oe_n),
  .sleep_mode(sleep_mode), .output_network_disable(output_network_disable),
  .io_buffer_disable(io_buffer_disable), .mute_drivers(mute_drivers),
  .pulse_generator_request(pulse_generator_request),
  .reseed_request(reseed_request), .restart_request(restart_request),
  .slip_request(slip_request), .phase_sync_alarm_set(phase_sync_alarm_set));

/* File: test/pin_board_model.sv */
`timescale 1ns/1ps
module pin_board_model
(
  input  wire logic clk,
  input  wire logic status_output_pin_out,
  input  wire logic status_output_pin_oe_n,
  output logic      pin_drive,
  output logic      wire_level
);
  // Board pull-up holds the line high whenever the device lets go
  assign wire_level = status_output_pin_oe_n ? 1'b1 :
                      status_output_pin_out;
  initial pin_drive = 1'b0;
  task automatic pulse(input int high_cycles);
    @(posedge clk);
    #2 pin_drive = 1'b1;
    repeat (high_cycles) @(posedge clk);
    #2 pin_drive = 1'b0;
    // Long low gap: edge detect needs a low sample and the slip alarm lands
    repeat (8) @(posedge clk);
  endtask
endmodule

/* File: test/gpio_function_select_tb.sv */
`timescale 1ns/1ps
module gpio_function_select_tb;
  localparam int high_len = 6;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic        ce = 1'b1;
  logic [7:0]  reg_rdata;
  logic [10:0] status = 11'h000;
  logic        pin_drive;
  logic        pin_out;
  logic        pin_oe_n;
  logic        wire_level;
  logic [8:0]  act;
  logic [7:0]  d;
  int          miscompares = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          cnt[9] = '{default: 0};
  int          base[9];
  int          e[9];
  byte         codes[7] = '{8'h05, 8'h07, 8'h09, 8'h0B, 8'h0D, 8'h11, 8'h03};

  gpio_function_select #(.slip_cycles(2)) gpio_function_select_inst (
    .clk(clk), .reset(reset), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .general_purpose_input(pin_drive),
    .status_output_pin_out(pin_out), .status_output_pin_oe_n(pin_oe_n),
    .alarm(status[0]), .serial_readback_line(status[1]),
    .sysref_unsynced(status[2]), .phase_status(status[3]),
    .sync_request_status(status[4]), .channel_fsm_busy(status[5]),
    .sysref_fsm_state(status[9:6]), .pulse_request_status(status[10]),
    .sleep_mode(act[0]), .mute_drivers(act[1]),
    .pulse_generator_request(act[2]), .reseed_request(act[3]),
    .restart_request(act[4]), .slip_request(act[5]),
    .phase_sync_alarm_set(act[6]), .output_network_disable(act[7]),
    .io_buffer_disable(act[8]));

  pin_board_model pin_board_model_inst (.clk(clk),
    .status_output_pin_out(pin_out), .status_output_pin_oe_n(pin_oe_n),
    .pin_drive(pin_drive), .wire_level(wire_level));

  always #25 clk = ~clk;

  // Counted on the falling edge, clear of the launching edge
  always @(negedge clk)
    if (!reset)
      foreach (cnt[i]) cnt[i] += int'(act[i]);

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      miscompares++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    #2 reg_addr = a;
    reg_wdata = v;
    reg_write = 1'b1;
    @(posedge clk);
    #2 reg_write = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    #2 reg_addr = a;
    reg_read = 1'b1;
    @(posedge clk);
    #2 reg_read = 1'b0;
    v = reg_rdata;
  endtask

  // Expected count of high cycles on each action output for one pin pulse
  task automatic run_pin(input int k, input bit on);
    base = cnt;
    e = '{default: 0};
    if (on)
      case (k)
        0: begin e[0] = high_len; e[7] = high_len; e[8] = high_len; end
        1: e[1] = high_len;
        2: e[2] = high_len;
        3: e[3] = 1;
        4: e[4] = 1;
        5: begin e[5] = 1; e[6] = 1; end
        default: ;
      endcase
    pin_board_model_inst.pulse(high_len);
    foreach (cnt[i]) check(16'(cnt[i] - base[i]), 16'(e[i]));
  endtask

  function automatic logic level_of(input logic [4:0] c, input logic [10:0] s);
    if (c <= 5'h09)
      return s[c];
    if (c == 5'h0A)
      return 1'b1;
    if (c == 5'h19)
      return s[10];
    return 1'b0;
  endfunction

  initial
  begin
    logic       ty;
    logic       en;
    logic       lv;
    logic [2:0] exp;
    logic [7:0] keep;
    void'($urandom(32'h3073680b));
    repeat (20) @(posedge clk);
    #2 reset = 1'b0;
    rd(8'h46, d);
    check(d, 8'h00);
    rd(8'h50, d);
    check(d, 8'h00);
    rd(8'h47, d);
    check(d, 8'h00);
    check({pin_out, pin_oe_n}, 2'b01);
    foreach (codes[k])
    begin
      wr(8'h46, codes[k] & 8'hFE);
      run_pin(k, 1'b0);
      wr(8'h46, codes[k]);
      run_pin(k, 1'b1);
      rd(8'h46, d);
      check(d, codes[k]);
      wr(8'h46, codes[k] & 8'hFE);
    end
    for (int c = 0; c < 32; c++)
    begin
      status = 11'($urandom);
      ty = 1'($urandom);
      en = ($urandom % 4) != 0;
      wr(8'h50, {1'b0, 5'(c), ty, en});
      repeat (2) @(posedge clk);
      #2 lv = level_of(5'(c), status);
      exp = !en ? 3'b011 : (ty ? {lv, 1'b0, lv} : {1'b0, lv, lv});
      check({pin_out, pin_oe_n, wire_level}, exp);
      rd(8'h50, d);
      check(d, {1'b0, 5'(c), ty, en});
    end
    // A write offered while ce is low must leave the register untouched
    keep = d;
    @(posedge clk);
    #2 ce = 1'b0;
    reg_addr = 8'h50;
    reg_wdata = 8'h2B;
    reg_write = 1'b1;
    @(posedge clk);
    #2 reg_write = 1'b0;
    ce = 1'b1;
    rd(8'h50, d);
    check(d, keep);
    results();
  end
endmodule
